// ===== inc/apm_map.svh
`ifndef APM_MAP_SVH
`define APM_MAP_SVH

// Task-file offsets
`define APM_OFS_FEATURES 10'h1f1
`define APM_OFS_ERROR    10'h1f1
`define APM_OFS_SECCNT   10'h1f2
`define APM_OFS_SECNUM   10'h1f3
`define APM_OFS_CYLLO    10'h1f4
`define APM_OFS_CYLHI    10'h1f5
`define APM_OFS_DRVHEAD  10'h1f6
`define APM_OFS_CMD      10'h1f7
`define APM_OFS_STATUS   10'h1f7

// Opcodes
`define APM_OP_IDLEI_A   8'h95
`define APM_OP_IDLEI_B   8'he1
`define APM_OP_STBY_A    8'h96
`define APM_OP_STBY_B    8'he2
`define APM_OP_STBYI_A   8'h94
`define APM_OP_STBYI_B   8'he0

// Opcode ranges that move the heads
`define APM_SEEK1_LO     8'h10
`define APM_SEEK1_HI     8'h4f
`define APM_SEEK2_LO     8'h70
`define APM_SEEK2_HI     8'h7f
`define APM_SEEK3_LO     8'hc4
`define APM_SEEK3_HI     8'hcb

// Field positions
`define APM_ST_BSY       7
`define APM_ST_DRDY      6
`define APM_ST_DSC       4
`define APM_ST_ERR       0
`define APM_ER_ABRT      2
`define APM_DH_DV        4

// Reset values
`define APM_SC_RST       8'h01
`define APM_SN_RST       8'h01

// Timer period decode
`define APM_SC_5S_MAX    8'hf0
`define APM_SC_30M_MAX   8'hfb
`define APM_SC_21M       8'hfc
`define APM_SC_8H        8'hfd
`define APM_CLK_HZ       25000000
`define APM_UNIT_S       5
`define APM_T30M_S       1800
`define APM_T21M_S       1260
`define APM_T8H_S        28800
`define APM_T21M15_S     1275
`define APM_TICK_CYC     (`APM_UNIT_S * `APM_CLK_HZ)
`define APM_U_30M        13'(`APM_T30M_S / `APM_UNIT_S)
`define APM_U_21M        13'(`APM_T21M_S / `APM_UNIT_S)
`define APM_U_8H         13'(`APM_T8H_S / `APM_UNIT_S)
`define APM_U_21M15      13'(`APM_T21M15_S / `APM_UNIT_S)

`endif

// ===== inc/apm_pkg.sv
package apm_pkg;

  typedef enum logic [0:0] {
    APM_PWR_IDLE = 1'b0,
    APM_PWR_STBY = 1'b1
  } apm_pwr_e;

  typedef enum logic [1:0] {
    APM_FSM_READY  = 2'b00,
    APM_FSM_SPINUP = 2'b01,
    APM_FSM_EXEC   = 2'b10,
    APM_FSM_DONE   = 2'b11
  } apm_fsm_e;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic       wr;
    logic       rd;
  } apm_bus_s;

  typedef struct packed {
    logic [7:0] op;
    logic       start;
  } apm_exec_s;

  typedef struct packed {
    apm_bus_s    bus_s1;
    apm_bus_s    bus_s2;
    logic        wr_d;
    logic        rd_d;
    logic        spin_s1;
    logic        spin_s2;
    apm_fsm_e    fsm;
    apm_pwr_e    pwr;
    logic [7:0]  feat;
    logic [7:0]  sc;
    logic [7:0]  sn;
    logic [7:0]  cl;
    logic [7:0]  ch;
    logic [7:0]  dh;
    logic [7:0]  err;
    logic [7:0]  op;
    logic        intrq;
    logic [7:0]  rdata;
    logic        spindle;
    logic        ape_en;
    logic [12:0] period;
    logic [12:0] units;
    logic [26:0] pre;
    logic        exec_start;
  } apm_state_s;

endpackage

// ===== src/apm_power_cmd.sv
`timescale 1ns/1ns
`default_nettype none
`include "apm_map.svh"

module apm_power_cmd #(
  parameter int         TICK_CYCLES = `APM_TICK_CYC,
  parameter logic [0:0] DRIVE_NUM   = 1'b0
) (
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  input  wire apm_pkg::apm_bus_s  host_bus_i,
  output logic [7:0]              host_rdata_o,
  output logic                    intrq_o,
  output logic                    spindle_on_o,
  output logic                    standby_o,
  input  wire logic               spin_ready_i,
  output apm_pkg::apm_exec_s      exec_o,
  input  wire logic               cmd_done_i,
  input  wire logic               cmd_err_i
);
  import apm_pkg::*;

  apm_state_s s_reg;
  apm_state_s s_next;

  logic       wr_ev;
  logic       rd_ev;
  logic       busy;
  logic       cmd_acc;
  logic       tick;
  logic [7:0] status_val;

  function automatic logic [12:0] period_units(input logic [7:0] sc);
    logic [12:0] u;
    u = 13'h0;
    if (sc <= `APM_SC_5S_MAX) begin
      u = {5'h0, sc};
    end else if (sc <= `APM_SC_30M_MAX) begin
      u = 13'(sc - `APM_SC_5S_MAX) * `APM_U_30M;
    end else if (sc == `APM_SC_21M) begin
      u = `APM_U_21M;
    end else if (sc == `APM_SC_8H) begin
      u = `APM_U_8H;
    end else begin
      u = `APM_U_21M15;
    end
    return u;
  endfunction

  function automatic logic needs_seek(input logic [7:0] op);
    return (op >= `APM_SEEK1_LO && op <= `APM_SEEK1_HI) ||
           (op >= `APM_SEEK2_LO && op <= `APM_SEEK2_HI) ||
           (op >= `APM_SEEK3_LO && op <= `APM_SEEK3_HI);
  endfunction

  function automatic logic is_idlei(input logic [7:0] op);
    return op == `APM_OP_IDLEI_A || op == `APM_OP_IDLEI_B;
  endfunction

  function automatic logic is_stby(input logic [7:0] op);
    return op == `APM_OP_STBY_A || op == `APM_OP_STBY_B;
  endfunction

  function automatic logic is_stbyi(input logic [7:0] op);
    return op == `APM_OP_STBYI_A || op == `APM_OP_STBYI_B;
  endfunction

  // Edges are taken on the second synchroniser stage only
  assign wr_ev   = s_reg.bus_s2.wr & ~s_reg.wr_d;
  assign rd_ev   = s_reg.bus_s2.rd & ~s_reg.rd_d;
  assign busy    = s_reg.fsm != APM_FSM_READY;
  // Writes while busy are dropped; host must wait for completion
  assign cmd_acc = wr_ev && !busy && s_reg.bus_s2.addr == `APM_OFS_CMD
                   && s_reg.dh[`APM_DH_DV] == DRIVE_NUM;
  assign tick    = s_reg.pre == 27'(TICK_CYCLES - 1);

  always_comb begin
    status_val                = 8'h0;
    status_val[`APM_ST_BSY]   = busy;
    status_val[`APM_ST_DRDY]  = !busy;
    status_val[`APM_ST_DSC]   = !busy;
    status_val[`APM_ST_ERR]   = s_reg.err != 8'h0;
  end

  always_comb begin
    s_next            = s_reg;
    s_next.bus_s1     = host_bus_i;
    s_next.bus_s2     = s_reg.bus_s1;
    s_next.wr_d       = s_reg.bus_s2.wr;
    s_next.rd_d       = s_reg.bus_s2.rd;
    s_next.spin_s1    = spin_ready_i;
    s_next.spin_s2    = s_reg.spin_s1;
    s_next.exec_start = 1'b0;

    // Power-down countdown runs only while idle and not busy
    if (!busy && s_reg.pwr == APM_PWR_IDLE && s_reg.ape_en) begin
      if (tick) begin
        s_next.pre   = 27'h0;
        s_next.units = s_reg.units - 13'h1;
        if (s_reg.units <= 13'h1) begin
          s_next.pwr     = APM_PWR_STBY;
          s_next.spindle = 1'b0;
        end
      end else begin
        s_next.pre = s_reg.pre + 27'h1;
      end
    end

    if (rd_ev) begin
      if (s_reg.bus_s2.addr == `APM_OFS_STATUS) begin
        s_next.rdata = status_val;
        s_next.intrq = 1'b0;
      end else if (s_reg.bus_s2.addr == `APM_OFS_ERROR) begin
        s_next.rdata = s_reg.err;
      end else if (s_reg.bus_s2.addr == `APM_OFS_SECCNT) begin
        s_next.rdata = s_reg.sc;
      end else if (s_reg.bus_s2.addr == `APM_OFS_SECNUM) begin
        s_next.rdata = s_reg.sn;
      end else if (s_reg.bus_s2.addr == `APM_OFS_CYLLO) begin
        s_next.rdata = s_reg.cl;
      end else if (s_reg.bus_s2.addr == `APM_OFS_CYLHI) begin
        s_next.rdata = s_reg.ch;
      end else if (s_reg.bus_s2.addr == `APM_OFS_DRVHEAD) begin
        s_next.rdata = s_reg.dh;
      end else begin
        s_next.rdata = 8'h0;
      end
    end

    if (wr_ev && !busy) begin
      if (s_reg.bus_s2.addr == `APM_OFS_FEATURES) begin
        s_next.feat = s_reg.bus_s2.data;
      end else if (s_reg.bus_s2.addr == `APM_OFS_SECCNT) begin
        s_next.sc = s_reg.bus_s2.data;
      end else if (s_reg.bus_s2.addr == `APM_OFS_SECNUM) begin
        s_next.sn = s_reg.bus_s2.data;
      end else if (s_reg.bus_s2.addr == `APM_OFS_CYLLO) begin
        s_next.cl = s_reg.bus_s2.data;
      end else if (s_reg.bus_s2.addr == `APM_OFS_CYLHI) begin
        s_next.ch = s_reg.bus_s2.data;
      end else if (s_reg.bus_s2.addr == `APM_OFS_DRVHEAD) begin
        s_next.dh = s_reg.bus_s2.data;
      end
    end

    case (s_reg.fsm)
      APM_FSM_READY: begin
        if (cmd_acc) begin
          s_next.op    = s_reg.bus_s2.data;
          s_next.intrq = 1'b0;
          s_next.err   = 8'h0;
          s_next.units = s_reg.period;
          s_next.pre   = 27'h0;
          if (is_idlei(s_reg.bus_s2.data)) begin
            // Timer enable and period are left as they are; the countdown reloads from period
            s_next.pwr     = APM_PWR_IDLE;
            s_next.spindle = 1'b1;
            s_next.fsm     = APM_FSM_DONE;
          end else if (is_stby(s_reg.bus_s2.data)) begin
            // Stopped spindle simply stays stopped
            s_next.pwr     = APM_PWR_STBY;
            s_next.spindle = 1'b0;
            s_next.ape_en  = s_reg.sc != 8'h0;
            s_next.period  = period_units(s_reg.sc);
            s_next.units   = period_units(s_reg.sc);
            if (s_reg.sc == 8'h0) begin
              s_next.ape_en = 1'b0;
            end
            // No wait for spin-down before completing
            s_next.fsm     = APM_FSM_DONE;
          end else if (is_stbyi(s_reg.bus_s2.data)) begin
            s_next.pwr     = APM_PWR_STBY;
            s_next.spindle = 1'b0;
            s_next.fsm     = APM_FSM_DONE;
          end else if (needs_seek(s_reg.bus_s2.data) && s_reg.pwr == APM_PWR_STBY) begin
            s_next.spindle = 1'b1;
            s_next.fsm     = APM_FSM_SPINUP;
          end else begin
            s_next.exec_start = 1'b1;
            s_next.fsm        = APM_FSM_EXEC;
          end
        end
      end
      APM_FSM_SPINUP: begin
        if (s_reg.spin_s2) begin
          s_next.pwr        = APM_PWR_IDLE;
          s_next.exec_start = 1'b1;
          s_next.fsm        = APM_FSM_EXEC;
        end
      end
      APM_FSM_EXEC: begin
        if (cmd_done_i) begin
          s_next.err[`APM_ER_ABRT] = cmd_err_i;
          s_next.fsm               = APM_FSM_DONE;
        end
      end
      APM_FSM_DONE: begin
        // Set wins over a status read in the same cycle
        s_next.intrq = 1'b1;
        s_next.units = s_reg.period;
        s_next.pre   = 27'h0;
        s_next.fsm   = APM_FSM_READY;
      end
      default: begin
        s_next.fsm = APM_FSM_READY;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg         <= '0;
      s_reg.fsm     <= APM_FSM_READY;
      s_reg.pwr     <= APM_PWR_IDLE;
      s_reg.sc      <= `APM_SC_RST;
      s_reg.sn      <= `APM_SN_RST;
      s_reg.spindle <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign host_rdata_o = s_reg.rdata;
  assign intrq_o      = s_reg.intrq;
  assign spindle_on_o = s_reg.spindle;
  assign standby_o    = s_reg.pwr[0];
  // One assignment for the whole carrier; a variable port takes a single driver
  assign exec_o       = '{op: s_reg.op, start: s_reg.exec_start};

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_complete;
    s_reg.fsm == APM_FSM_DONE ##1 (s_reg.fsm == APM_FSM_READY && s_reg.intrq);
  endsequence

  // Busy for exactly one cycle, then free again
  sequence s_one_busy;
    busy ##1 !busy;
  endsequence

  property p_idlei;
    cmd_acc && is_idlei(s_reg.bus_s2.data) |=> s_complete ##0 (s_reg.spindle && !s_reg.pwr[0]);
  endproperty
  a_idlei: assert property (p_idlei) else $error("idle immediate did not complete in idle");

  property p_idlei_timer;
    cmd_acc && (is_idlei(s_reg.bus_s2.data) || is_stbyi(s_reg.bus_s2.data))
      |=> s_reg.ape_en == $past(s_reg.ape_en) && s_reg.period == $past(s_reg.period);
  endproperty
  a_idlei_timer: assert property (p_idlei_timer) else $error("immediate command changed timer setup");

  property p_stby;
    cmd_acc && is_stby(s_reg.bus_s2.data) |=> s_complete ##0 (s_reg.pwr[0] && !s_reg.spindle);
  endproperty
  a_stby: assert property (p_stby) else $error("standby did not complete in two cycles");

  property p_ape_on;
    cmd_acc && is_stby(s_reg.bus_s2.data) && s_reg.sc != 8'h0
      |=> s_reg.ape_en && s_reg.period == period_units($past(s_reg.sc));
  endproperty
  a_ape_on: assert property (p_ape_on) else $error("nonzero count did not arm timer");

  property p_ape_off;
    cmd_acc && is_stby(s_reg.bus_s2.data) && s_reg.sc == 8'h0 |=> !s_reg.ape_en;
  endproperty
  a_ape_off: assert property (p_ape_off) else $error("zero count left timer armed");

  property p_expire;
    !busy && !s_reg.pwr[0] && s_reg.ape_en && tick && s_reg.units == 13'h1 && !cmd_acc
      |=> s_reg.pwr[0] && !s_reg.spindle;
  endproperty
  a_expire: assert property (p_expire) else $error("timer expiry did not enter standby");

  property p_seek;
    cmd_acc && needs_seek(s_reg.bus_s2.data) && s_reg.pwr[0]
      |=> s_reg.fsm == APM_FSM_SPINUP && s_reg.spindle && !s_reg.exec_start;
  endproperty
  a_seek: assert property (p_seek) else $error("seek in standby did not spin up first");

  property p_stbyi;
    cmd_acc && is_stbyi(s_reg.bus_s2.data) |=> s_complete ##0 s_reg.pwr[0];
  endproperty
  a_stbyi: assert property (p_stbyi) else $error("standby immediate did not complete");

  property p_status;
    // A completion in the same cycle keeps the interrupt raised
    rd_ev && s_reg.bus_s2.addr == `APM_OFS_STATUS && s_reg.fsm != APM_FSM_DONE
      |=> host_rdata_o[`APM_ST_BSY] == $past(busy) && !intrq_o;
  endproperty
  a_status: assert property (p_status) else $error("status read wrong busy or kept interrupt");

  property p_reload;
    cmd_acc && !is_stby(s_reg.bus_s2.data) |=> s_reg.units == s_reg.period && s_reg.pre == 27'h0;
  endproperty
  a_reload: assert property (p_reload) else $error("command did not reload timer");

  property p_irq_wins;
    s_reg.fsm == APM_FSM_DONE |=> intrq_o;
  endproperty
  a_irq_wins: assert property (p_irq_wins) else $error("completion interrupt was not raised");

  property p_no_wait;
    cmd_acc && (is_stby(s_reg.bus_s2.data) || is_stbyi(s_reg.bus_s2.data)) |=> s_one_busy ##0 intrq_o;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("standby waited before completing");

  property p_stopped;
    cmd_acc && is_stby(s_reg.bus_s2.data) && !s_reg.spindle
      |=> !s_reg.spindle && s_reg.fsm == APM_FSM_DONE;
  endproperty
  a_stopped: assert property (p_stopped) else $error("standby on stopped spindle did not just complete");

  property p_spinup_hold;
    s_reg.fsm == APM_FSM_SPINUP && !s_reg.spin_s2
      |=> s_reg.fsm == APM_FSM_SPINUP && s_reg.pwr[0] && !s_reg.exec_start;
  endproperty
  a_spinup_hold: assert property (p_spinup_hold) else $error("command started before motor at speed");

  property p_start_pulse;
    exec_o.start |=> !exec_o.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("executor start held over one cycle");

  property p_stby_hold;
    !busy && s_reg.pwr[0] && !cmd_acc |=> $stable(s_reg.units) && s_reg.pwr[0];
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("countdown ran or mode changed in standby");

  property p_err_read;
    rd_ev && s_reg.bus_s2.addr == `APM_OFS_ERROR |=> host_rdata_o == $past(s_reg.err);
  endproperty
  a_err_read: assert property (p_err_read) else $error("error report read returned wrong value");

endmodule // apm_power_cmd
`default_nettype wire

// ===== sim/apm_exec_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the motor and the command executor behind the block
module apm_exec_model #(
  parameter int SPIN_CYC = 5
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic spindle_on_i,
  input  wire logic start_i,
  input  wire logic fail_i,
  input  wire logic slow_i,
  output logic      spin_ready_o,
  output logic      cmd_done_o,
  output logic      cmd_err_o
);
  int spin_cnt;
  int run_cnt;

  // Motor loses speed at once when stopped, so no stale at-speed indication
  assign spin_ready_o = (spin_cnt == SPIN_CYC);

  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      spin_cnt   <= SPIN_CYC;
      run_cnt    <= 0;
      cmd_done_o <= 1'b0;
      cmd_err_o  <= 1'b0;
    end else begin
      if (!spindle_on_i) begin
        spin_cnt <= 0;
      end else if (spin_cnt < SPIN_CYC) begin
        spin_cnt <= spin_cnt + 1;
      end
      if (start_i) begin
        run_cnt <= slow_i ? 20 : 2;
      end else if (run_cnt > 0) begin
        run_cnt <= run_cnt - 1;
      end
      cmd_done_o <= (run_cnt == 1);
      cmd_err_o  <= (run_cnt == 1) && fail_i;
    end
  end
endmodule // apm_exec_model
`default_nettype wire

// ===== sim/ata_power_mode_commands_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "apm_map.svh"
module ata_power_mode_commands_tb;
  import apm_pkg::*;
  localparam int TICK = 16;
  logic       clk;
  logic       rst;
  apm_bus_s   hb;
  logic [7:0] rdata;
  logic       intrq;
  logic       spin_on;
  logic       stby;
  logic       spin_rdy;
  apm_exec_s  ex;
  logic       done;
  logic       err;
  logic       fail;
  logic       slow;
  logic [7:0] seed;
  logic [7:0] d;
  logic [7:0] op;
  int         err_total;
  int         checks_done;
  logic [7:0] ops [6] = '{`APM_OP_IDLEI_A, `APM_OP_IDLEI_B, `APM_OP_STBY_A,
                          `APM_OP_STBY_B, `APM_OP_STBYI_A, `APM_OP_STBYI_B};

  apm_power_cmd #(.TICK_CYCLES(TICK), .DRIVE_NUM(1'b0)) u_apm_power_cmd (
    .core_clk_i(clk), .sys_rst_i(rst), .host_bus_i(hb), .host_rdata_o(rdata),
    .intrq_o(intrq), .spindle_on_o(spin_on), .standby_o(stby),
    .spin_ready_i(spin_rdy), .exec_o(ex), .cmd_done_i(done), .cmd_err_i(err));

  apm_exec_model u_apm_exec_model (
    .core_clk_i(clk), .sys_rst_i(rst), .spindle_on_i(spin_on), .start_i(ex.start),
    .fail_i(fail), .slow_i(slow), .spin_ready_o(spin_rdy), .cmd_done_o(done),
    .cmd_err_o(err));

  always #20 clk = ~clk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic exp_stby(input logic [7:0] o);
    return o == `APM_OP_STBY_A || o == `APM_OP_STBY_B || o == `APM_OP_STBYI_A || o == `APM_OP_STBYI_B;
  endfunction

  function automatic logic [15:0] units_of(input logic [7:0] s);
    if (s <= 8'hf0) return {8'h00, s};
    if (s <= 8'hfb) return 16'({8'h00, s} - 16'h00f0) * 16'h0168;
    if (s == 8'hfc) return 16'h00fc;
    if (s == 8'hfd) return 16'h1680;
    return 16'h00ff;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Strobes stay high and low long enough for the two-flop synchroniser
  task automatic bus_wr(input logic [9:0] a, input logic [7:0] v);
    hb.addr <= a;
    hb.data <= v;
    @(posedge clk);
    hb.wr <= 1'b1;
    repeat (4) @(posedge clk);
    hb.wr <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic bus_rd(input logic [9:0] a, output logic [7:0] v);
    hb.addr <= a;
    @(posedge clk);
    hb.rd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 v = rdata;
    @(posedge clk);
    hb.rd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] o, input logic [7:0] sc);
    bus_wr(`APM_OFS_SECCNT, sc);
    bus_wr(`APM_OFS_CMD, o);
  endtask

  task automatic wait_irq(input int lim);
    int n = 0;
    while (intrq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    check("intrq", {15'h0000, intrq}, 16'h0001);
  endtask

  task automatic measure(input logic [7:0] sc);
    int n = 4;
    bus_wr(`APM_OFS_CMD, `APM_OP_IDLEI_A);
    while (stby !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    check("timer_units", 16'((n + TICK / 2) / TICK), units_of(sc));
    check("timer_spindle", {15'h0000, spin_on}, 16'h0000);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hb = '0;
    fail = 1'b0;
    slow = 1'b0;
    seed = 8'h1b;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_rd(`APM_OFS_SECCNT, d);
    check("sc_reset", d, `APM_SC_RST);
    bus_rd(`APM_OFS_SECNUM, d);
    check("sn_reset", d, `APM_SN_RST);
    bus_rd(10'h1f0, d);
    check("unmapped", d, 8'h00);
    bus_wr(`APM_OFS_DRVHEAD, 8'ha0);
    // Fixed walk over every opcode, then random order; standby gets a zero count, the rest a random one
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      op = (i < 6) ? ops[i] : ops[seed % 6];
      cmd(op, (op == `APM_OP_STBY_A || op == `APM_OP_STBY_B) ? 8'h00 : seed);
      wait_irq(20);
      check("standby", {15'h0000, stby}, {15'h0000, exp_stby(op)});
      check("spindle", {15'h0000, spin_on}, {15'h0000, !exp_stby(op)});
      bus_rd(`APM_OFS_STATUS, d);
      check("status", d, 8'h50);
      check("intrq_clr", {15'h0000, intrq}, 16'h0000);
      repeat (60) @(posedge clk);
      check("no_timer", {15'h0000, stby}, {15'h0000, exp_stby(op)});
    end
    foreach (ops[i]) begin
      if (i < 3) begin
        op = i == 0 ? 8'h03 : (i == 1 ? 8'hf1 : 8'hfe);
        cmd(`APM_OP_STBY_A, op);
        wait_irq(20);
        bus_wr(`APM_OFS_CMD, `APM_OP_IDLEI_A);
        repeat (30) @(posedge clk);
        measure(op);
      end
    end
    cmd(`APM_OP_STBY_B, 8'h00);
    wait_irq(20);
    bus_wr(`APM_OFS_CMD, `APM_OP_IDLEI_B);
    repeat (200) @(posedge clk);
    check("timer_off", {15'h0000, stby}, 16'h0000);
    cmd(`APM_OP_STBYI_A, 8'h01);
    wait_irq(20);
    fail <= 1'b1;
    slow <= 1'b1;
    bus_wr(`APM_OFS_CMD, 8'h20);
    for (int n = 0; n < 100 && ex.start !== 1'b1; n++) begin
      @(negedge clk);
    end
    check("seek_spun", {14'h0000, spin_rdy, stby}, 16'h0002);
    check("exec_start", {15'h0000, ex.start}, 16'h0001);
    check("exec_op", ex.op, 8'h20);
    wait_irq(60);
    bus_rd(`APM_OFS_STATUS, d);
    check("err_status", d, 8'h51);
    bus_rd(`APM_OFS_ERROR, d);
    check("err_report", d, 8'h04);
    // Seek in idle runs at once; a clean finish leaves no error
    fail <= 1'b0;
    bus_wr(`APM_OFS_CMD, 8'h20);
    wait_irq(60);
    bus_rd(`APM_OFS_STATUS, d);
    check("ok_status", d, 8'h50);
    bus_rd(`APM_OFS_ERROR, d);
    check("ok_report", d, 8'h00);
    bus_wr(`APM_OFS_DRVHEAD, 8'hb0);
    bus_wr(`APM_OFS_CMD, `APM_OP_STBYI_B);
    repeat (10) @(posedge clk);
    check("other_drive", {14'h0000, intrq, stby}, 16'h0000);
    tally_and_finish();
  end

  // Longest path is the 360-unit countdown; this leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule // ata_power_mode_commands_tb
`default_nettype wire
